// >>> rtl/bcmd_pkg.sv
package bcmd_pkg;

  localparam logic [7:0] BCMD_CMD_OFFSET = 8'h04;
  localparam logic [7:0] BCMD_STS_OFFSET = 8'h06;
  localparam logic [15:0] BCMD_CMD_RESET = 16'h0000;
  localparam int BCMD_IO_EN_BIT = 0;
  localparam int BCMD_MEM_EN_BIT = 1;
  localparam int BCMD_BM_EN_BIT = 2;
  localparam int BCMD_SERR_EN_BIT = 8;
  localparam int BCMD_SSE_BIT = 14;
  localparam logic [15:0] BCMD_CMD_WMASK = 16'h0107;
  localparam logic [15:0] BCMD_STS_FIXED = 16'h00A0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } bcmd_cfg_req_t;

  typedef struct packed {
    logic frame_cyc;
    logic sba_cyc;
    logic mem_hit;
    logic io_hit;
    logic pref_hit;
  } bcmd_agp_req_t;

  typedef enum logic [1:0] {
    BCMD_DEC_NONE = 2'b00,
    BCMD_DEC_MEM = 2'b01,
    BCMD_DEC_IO = 2'b10,
    BCMD_DEC_ABORT = 2'b11
  } bcmd_dec_t;

endpackage : bcmd_pkg

// >>> rtl/bcmd_bridge_command.sv
`timescale 1ns/1ps
// What this block does
// [RL1] Command register lives at config offset 04h, 16 bits, resets to zero.
// [RL2] Bit 9 fast back-to-back enable reads zero, writes ignored.
// [RL3] System errors are reported as a message over the hub link, no pin.
// [RL4] With bit 8 clear, no system-error message is sent.
// [RL5] With bit 8 set, enabled bridge errors send a message and mark status.
// [RL6] Bit 7 address/data stepping reads zero.
// [RL7] Bit 6 parity response reads zero; no primary-side parity checking.
// [RL8] Bit 4 memory-write-and-invalidate enable reads zero.
// [RL9] Bit 3 special cycle enable reads zero.
// [RL10] With bit 2 clear, graphics master frame cycles are ignored and master abort.
// [RL11] With bit 2 set, frame cycles accepted only inside a valid decode range.
// [RL12] Sideband and pipelined requests are accepted regardless of bit 2.
// [RL13] With bit 1 clear, every memory window is disabled.
// [RL14] With bit 1 set, memory and prefetchable windows decode.
// [RL15] With bit 0 clear, all I/O forwarding is disabled.
// [RL16] The I/O window decodes only once software has set bit 0.
// [RL17] Sending a system-error message sets status bit 14; write one clears it.
// [RL18] Reserved bits 15:10 and 5 read zero, writes ignored.
module bcmd_bridge_command (
  input wire logic clk,
  input wire logic rst,
  input bcmd_pkg::bcmd_cfg_req_t cfg_req,
  input bcmd_pkg::bcmd_agp_req_t agp_req,
  input wire logic bridge_error,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic agp_accept,
  output bcmd_pkg::bcmd_dec_t agp_decode,
  output logic hub_syserr_msg,
  output logic memory_space_enable,
  output logic io_space_enable,
  output logic bus_master_enable
);
  import bcmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic sse_ff;
  logic nxt_sse;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic accept_ff;
  logic nxt_accept;
  bcmd_dec_t decode_ff;
  bcmd_dec_t nxt_decode;
  logic msg_ff;
  logic nxt_msg;

  function automatic logic [15:0] apply_be(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    apply_be = (old & ~lane) | (wd & lane);
  endfunction : apply_be

  ////////////////////////////////////////////////////////////////////////////

  // Only the three enables and the message enable are storage; the mask keeps
  // every hardwired and reserved bit at zero whatever software writes.
  always_comb begin
    nxt_cmd = cmd_ff;
    if (cfg_req.wr && cfg_req.addr == BCMD_CMD_OFFSET) begin // [RL1]
      nxt_cmd = apply_be(cmd_ff, cfg_req.wdata, cfg_req.be, BCMD_CMD_WMASK); // [RL2] [RL6] [RL7] [RL8] [RL9] [RL18]
    end
  end

  // A new message in the same cycle as a write-one clear keeps the flag set.
  always_comb begin
    nxt_msg = bridge_error && cmd_ff[BCMD_SERR_EN_BIT]; // [RL3] [RL4] [RL5]
    nxt_sse = sse_ff;
    if (cfg_req.wr && cfg_req.addr == BCMD_STS_OFFSET && cfg_req.be[1] && cfg_req.wdata[BCMD_SSE_BIT]) begin
      nxt_sse = 1'b0; // [RL17]
    end
    if (nxt_msg) begin
      nxt_sse = 1'b1; // [RL5] [RL17]
    end
  end

  always_comb begin
    nxt_rvalid = cfg_req.rd;
    nxt_rdata = 16'h0000;
    if (cfg_req.rd && cfg_req.addr == BCMD_CMD_OFFSET) begin
      nxt_rdata = cmd_ff & BCMD_CMD_WMASK; // [RL18]
    end else if (cfg_req.rd && cfg_req.addr == BCMD_STS_OFFSET) begin
      nxt_rdata = BCMD_STS_FIXED;
      nxt_rdata[BCMD_SSE_BIT] = sse_ff;
    end
  end

  // Frame cycles need the master enable and a hit in an enabled window;
  // sideband and pipelined requests skip the master enable entirely.
  always_comb begin
    logic mem_ok;
    logic io_ok;
    mem_ok = cmd_ff[BCMD_MEM_EN_BIT] && (agp_req.mem_hit || agp_req.pref_hit); // [RL13] [RL14]
    io_ok = cmd_ff[BCMD_IO_EN_BIT] && agp_req.io_hit; // [RL15] [RL16]
    nxt_accept = 1'b0;
    nxt_decode = BCMD_DEC_NONE;
    if (agp_req.sba_cyc) begin
      nxt_accept = 1'b1; // [RL12]
      nxt_decode = BCMD_DEC_MEM;
    end else if (agp_req.frame_cyc) begin
      if (!cmd_ff[BCMD_BM_EN_BIT]) begin
        nxt_decode = BCMD_DEC_ABORT; // [RL10]
      end else if (mem_ok) begin
        nxt_accept = 1'b1; // [RL11]
        nxt_decode = BCMD_DEC_MEM;
      end else if (io_ok) begin
        nxt_accept = 1'b1; // [RL11]
        nxt_decode = BCMD_DEC_IO;
      end else begin
        nxt_decode = BCMD_DEC_ABORT; // [RL11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= BCMD_CMD_RESET; // [RL1]
      sse_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      accept_ff <= 1'b0;
      decode_ff <= BCMD_DEC_NONE;
      msg_ff <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      sse_ff <= nxt_sse;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      accept_ff <= nxt_accept;
      decode_ff <= nxt_decode;
      msg_ff <= nxt_msg;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign agp_accept = accept_ff;
  assign agp_decode = decode_ff;
  assign hub_syserr_msg = msg_ff;
  assign memory_space_enable = cmd_ff[BCMD_MEM_EN_BIT];
  assign io_space_enable = cmd_ff[BCMD_IO_EN_BIT];
  assign bus_master_enable = cmd_ff[BCMD_BM_EN_BIT];

endmodule : bcmd_bridge_command

// >>> verif/bcmd_far_side.sv
`timescale 1ns/1ps
// Software and graphics master side: every request stands one cycle, then the lines fall back to idle.
module bcmd_far_side (
  output bcmd_pkg::bcmd_cfg_req_t cfg_req,
  output bcmd_pkg::bcmd_agp_req_t agp_req,
  output logic bridge_error,
  input wire logic clk
);
  import bcmd_pkg::*;
  initial {cfg_req, agp_req, bridge_error} = '0;
  task op(input bcmd_cfg_req_t c, input bcmd_agp_req_t g, input logic e);
    @(posedge clk) {cfg_req, agp_req, bridge_error} <= {c, g, e};
    @(posedge clk) {cfg_req, agp_req, bridge_error} <= '0;
    #1;
  endtask : op
endmodule : bcmd_far_side

// >>> verif/bcmd_bridge_command_props.sv
`timescale 1ns/1ps
module bcmd_bridge_command_props (
  input wire logic clk,
  input wire logic rst,
  input bcmd_pkg::bcmd_cfg_req_t cfg_req,
  input bcmd_pkg::bcmd_agp_req_t agp_req,
  input wire logic bridge_error,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic agp_accept,
  input bcmd_pkg::bcmd_dec_t agp_decode,
  input wire logic hub_syserr_msg,
  input wire logic memory_space_enable,
  input wire logic io_space_enable,
  input wire logic bus_master_enable
);
  import bcmd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Sideband wins a shared cycle, so the frame checks leave that case out.
  wire f = agp_req.frame_cyc & ~agp_req.sba_cyc;
  wire m = agp_req.mem_hit | agp_req.pref_hit;
  wire ab = agp_decode == BCMD_DEC_ABORT && !agp_accept;
  // Mirror of the message enable, rebuilt from the config writes seen at the ports.
  logic serr_en_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serr_en_ff <= 1'b0;
    end else if (cfg_req.wr && cfg_req.addr == BCMD_CMD_OFFSET && cfg_req.be[1]) begin
      serr_en_ff <= cfg_req.wdata[BCMD_SERR_EN_BIT];
    end
  end
  AST_NOMSG: assert property (bridge_error && !serr_en_ff |=> !hub_syserr_msg) else $error("message while off");
  AST_SENDMSG: assert property (bridge_error && serr_en_ff |=> hub_syserr_msg) else $error("message lost");
  AST_RD: assert property (cfg_req.rd |=> cfg_rvalid) else $error("no rvalid");
  AST_RO: assert property (
    cfg_rvalid && $past(cfg_req.addr) == 8'h04 |-> (cfg_rdata & 16'hFEF8) == 16'h0000) else $error("fixed bit");
  AST_MSG: assert property (hub_syserr_msg |-> $past(bridge_error)) else $error("stray message");
  AST_BM: assert property (f && !bus_master_enable |=> ab) else $error("frame taken");
  AST_SBA: assert property (agp_req.sba_cyc |=> agp_accept) else $error("sideband refused");
  AST_MEM: assert property (f && !memory_space_enable && !agp_req.io_hit |=> ab) else $error("mem open");
  AST_IO: assert property (f && !io_space_enable && !m |=> ab) else $error("io open");
  AST_HIT: assert property (
    f && bus_master_enable && memory_space_enable && m |=> agp_accept && agp_decode == BCMD_DEC_MEM) else $error("mem miss");
endmodule : bcmd_bridge_command_props
bind bcmd_bridge_command bcmd_bridge_command_props i_bcmd_bridge_command_props (.*);

// >>> verif/bcmd_bridge_command_tb.sv
`timescale 1ns/1ps
module bcmd_bridge_command_tb;
  import bcmd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bridge_error, cfg_rvalid, agp_accept, hub_syserr_msg, memory_space_enable, io_space_enable, bus_master_enable;
  logic [15:0] cfg_rdata;
  bcmd_cfg_req_t cfg_req;
  bcmd_agp_req_t agp_req;
  bcmd_dec_t agp_decode;
  int fail_count = 0;
  int num_checks = 0;
  bcmd_bridge_command i_bcmd_bridge_command (.*);
  bcmd_far_side i_bcmd_far_side (.*);
  initial forever #20 clk = ~clk;
  task chk(input logic [15:0] s, input logic [15:0] e, input string n);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Config word packs wr, rd, addr, be, wdata; answer packs accept, decode, message.
  task step(input logic [27:0] c, input bcmd_agp_req_t g, input logic b, input logic [15:0] r, input logic [3:0] o);
    i_bcmd_far_side.op(c, g, b);
    if (c[26]) chk(cfg_rdata, r, "rdata");
    if (c[26]) chk({15'h0000, cfg_rvalid}, 16'h0001, "rvalid");
    chk({agp_accept, g.sba_cyc ? 2'h0 : agp_decode, hub_syserr_msg}, o, "answer");
  endtask : step
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (1000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step(28'h4130000, 5'h14, 1'b1, 16'h0000, 4'h6);
    step(28'h41B0000, 5'h08, 1'b0, 16'h00A0, 4'h8);
    step(28'h813FFFF, 5'h00, 1'b0, 16'h0000, 4'h0);
    chk({13'h0000, bus_master_enable, memory_space_enable, io_space_enable}, 16'h0007, "enables");
    step(28'h4130000, 5'h14, 1'b1, 16'h0107, 4'hB);
    step(28'h41B0000, 5'h11, 1'b0, 16'h40A0, 4'hA);
    step(28'h81A4000, 5'h12, 1'b0, 16'h0000, 4'hC);
    step(28'h41B0000, 5'h00, 1'b0, 16'h00A0, 4'h0);
    step(28'h8110005, 5'h00, 1'b0, 16'h0000, 4'h0);
    step(28'h4130000, 5'h14, 1'b1, 16'h0105, 4'h7);
    step(28'h81A4000, 5'h00, 1'b1, 16'h0000, 4'h1);
    step(28'h41B0000, 5'h00, 1'b0, 16'h40A0, 4'h0);
    step(28'h8130006, 5'h00, 1'b0, 16'h0000, 4'h0);
    chk({13'h0000, bus_master_enable, memory_space_enable, io_space_enable}, 16'h0006, "enables");
    step(28'h4130000, 5'h12, 1'b1, 16'h0006, 4'h6);
    end_of_test;
  end
endmodule : bcmd_bridge_command_tb
